// [hdl/rx_filter_pkg.sv]
package rx_filter_pkg;
   // Register word addresses (byte address = offset)
   localparam logic [7:0] CTRL_ADDR      = 8'h00;
   localparam logic [7:0] VTYPE_ADDR     = 8'h04;
   localparam logic [7:0] PORT_SELECT_ADDR    = 8'h08;
   localparam logic [7:0] DP_ADDR_ADDR   = 8'h0C;
   localparam logic [7:0] DP_DATA_ADDR   = 8'h10;
   localparam logic [7:0] DP_STAT_ADDR   = 8'h14;
   localparam logic [7:0] PAE_SEL_ADDR   = 8'h18;
   localparam logic [7:0] PAE_LO_ADDR    = 8'h1C;
   localparam logic [7:0] PAE_HI_ADDR    = 8'h20;
   // Control bit positions
   localparam int CTL_UCAST_ALL  = 0;
   localparam int CTL_MCAST_ALL  = 1;
   localparam int CTL_BCAST_DISC = 2;
   localparam int CTL_DPF        = 3;
   localparam int CTL_SPF        = 4;
   localparam int CTL_MHF        = 5;
   localparam int CTL_DHF        = 6;
   localparam int CTL_UNTAG      = 7;
   localparam int CTL_VF         = 8;
   localparam int CTL_STRIP      = 9;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0060;
   // Perfect entry fields
   localparam int PAE_VALID_BIT = 49;
   localparam int PAE_TYPE_BIT  = 48;
   localparam int PAE_W         = 50;
   localparam int N_PAE         = 33;
   // Filter RAM layout
   localparam int RAM_WORDS           = 256;
   localparam logic [7:0] HASH_BASE   = 8'h00;
   localparam logic [7:0] VLAN_BASE   = 8'h80;
   localparam logic [3:0] PORT_FILTER = 4'h1;
   localparam logic [15:0] VTYPE_RESET = 16'h8100;
   localparam logic [15:0] VTYPE_STD   = 16'h8100;
   localparam logic [31:0] CRC_INIT    = 32'hFFFF_FFFF;
   localparam logic [31:0] RAM_CLEAR   = 32'h0000_0000;
endpackage

// [hdl/rx_filter_engine.sv]
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] Global unicast, multicast accept, broadcast discard
// [R02] Compare both addresses against 33 entries
// [R03] Entry used only with valid bit 49
// [R04] Bit 48 picks source or destination match
// [R05] Separate enables for destination, source perfect
// [R06] Both enabled: both must match, hash allowed
// [R07] Entries writable while running, used later
// [R08] Hash for multicast/unicast by enables, never broadcast
// [R09] Hash CRC starts all ones per frame
// [R10] Per byte CRC update with F terms
// [R11] CRC 31:28 word, 27:23 bit select
// [R12] Hash table is 16 words, 512 bits
// [R13] Tag when type is programmed or 8100h
// [R14] Only first tag after source address
// [R15] Untagged frames passed or discarded by control
// [R16] Tag stripped, VID and tagged flag reported
// [R17] VID bit in VLAN table gates frame
// [R18] Filter RAM reached through data port
// [R19] RAM cleared after reset, port waits meanwhile
// [R20] Host rechecks hash-accepted destination addresses
// [R21] Value_a resets to 8100h
// [R22] VID 11:5 word, 4:0 bit, separate region
// [R23] Decision final before status handed onward
module rx_filter_engine
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        rx_valid,
   input  wire logic        rx_sof,
   input  wire logic        rx_eof,
   input  wire logic [7:0]  rx_data,
   output logic             out_valid,
   output logic      [7:0]  out_data,
   output logic             out_sof,
   output logic             out_eof,
   output logic             stat_valid,
   output logic             stat_drop,
   output logic             stat_tagged,
   output logic      [15:0] stat_vlan_tag,
   output logic             stat_hash_hit
);
   import rx_filter_pkg::*;

   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0]  d);
      logic [7:0]  f;
      logic [31:0] n;
      f = '0;
      n = '0;
      for (int i = 0; i < 6; i++) begin
         f[i] = c[31-i] ^ d[i];
      end
      f[6] = c[25] ^ f[0] ^ d[6];
      f[7] = c[24] ^ f[1] ^ d[7];
      n[31] = c[23] ^ f[2];
      n[30] = c[22] ^ f[0] ^ f[3];
      n[29] = c[21] ^ f[0] ^ f[1] ^ f[4];
      n[28] = c[20] ^ f[1] ^ f[2] ^ f[5];
      n[27] = c[19] ^ f[2] ^ f[3] ^ f[6];
      n[26] = c[18] ^ f[3] ^ f[4] ^ f[7];
      n[25] = c[17] ^ f[4] ^ f[5];
      n[24] = c[16] ^ f[5] ^ f[6];
      n[23] = c[15] ^ f[0] ^ f[6] ^ f[7];
      n[22] = c[14] ^ f[1] ^ f[7];
      n[21] = c[13] ^ f[2];
      n[20] = c[12] ^ f[3];
      n[19] = c[11] ^ f[0] ^ f[4];
      n[18] = c[10] ^ f[0] ^ f[1] ^ f[5];
      n[17] = c[9] ^ f[0] ^ f[1] ^ f[2] ^ f[6];
      n[16] = c[8] ^ f[1] ^ f[2] ^ f[3] ^ f[7];
      n[15] = c[7] ^ f[0] ^ f[2] ^ f[3] ^ f[4];
      n[14] = c[6] ^ f[0] ^ f[1] ^ f[3] ^ f[4] ^ f[5];
      n[13] = c[5] ^ f[1] ^ f[2] ^ f[4] ^ f[5] ^ f[6];
      n[12] = c[4] ^ f[0] ^ f[2] ^ f[3] ^ f[5] ^ f[6] ^ f[7];
      n[11] = c[3] ^ f[0] ^ f[1] ^ f[3] ^ f[4] ^ f[6] ^ f[7];
      n[10] = c[2] ^ f[1] ^ f[2] ^ f[4] ^ f[5] ^ f[7];
      n[9]  = c[1] ^ f[0] ^ f[2] ^ f[3] ^ f[5] ^ f[6];
      n[8]  = c[0] ^ f[0] ^ f[1] ^ f[3] ^ f[4] ^ f[6] ^ f[7];
      n[7]  = f[0] ^ f[1] ^ f[2] ^ f[4] ^ f[5] ^ f[7];
      n[6]  = f[1] ^ f[2] ^ f[3] ^ f[5] ^ f[6];
      n[5]  = f[2] ^ f[3] ^ f[4] ^ f[6] ^ f[7];
      n[4]  = f[3] ^ f[4] ^ f[5] ^ f[7];
      n[3]  = f[4] ^ f[5] ^ f[6];
      n[2]  = f[5] ^ f[6] ^ f[7];
      n[1]  = f[6] ^ f[7];
      n[0]  = f[7];
      return n; // [R10]
   endfunction

   typedef enum logic [2:0] {S_IDLE, S_HDR, S_LOOK, S_BODY, S_DONE} rx_state_t;
   typedef enum logic [1:0] {L_HASH, L_VLAN, L_FINISH} look_t;

   // Registers
   logic [31:0]        ctrl_r;
   logic [15:0]        vtype_r;
   logic [3:0]         port_select_r;
   logic [7:0]         dp_addr_r;
   logic [5:0]         pae_sel_r;
   logic [31:0]        pae_lo_r;
   logic [PAE_W-1:0]   pae_r [N_PAE];
   logic [31:0]        ram [RAM_WORDS];
   logic               init_busy_r;
   logic [7:0]         init_addr_r;

   // Frame parsing
   rx_state_t          state_r;
   look_t              look_r;
   logic [4:0]         bcnt_r;
   logic [47:0]        da_r;
   logic [47:0]        sa_r;
   logic [15:0]        type_r;
   logic [15:0]        tci_r;
   logic [31:0]        crc_r;
   logic [31:0]        ram_q_r;
   logic               hash_bit_r;
   logic               eof_seen_r;

   logic               wb_req;
   logic               dp_hit;
   logic               ram_port_stall;
   logic               is_tag;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign dp_hit = wb_adr_i == DP_DATA_ADDR && port_select_r == PORT_FILTER;
   // Data port waits while the RAM is being cleared
   assign ram_port_stall = dp_hit && init_busy_r; // [R19]
   assign is_tag = type_r == vtype_r || type_r == VTYPE_STD; // [R13]

   // Wishbone ack, one cycle after request; data port accesses stalled while clearing
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req && !ram_port_stall;
      end
   end

   // Control registers, writable at any time
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ctrl_r    <= CTRL_RESET;
         vtype_r   <= VTYPE_RESET; // [R21]
         port_select_r  <= '0;
         dp_addr_r <= '0;
         pae_sel_r <= '0;
         pae_lo_r  <= '0;
      end else if (wb_req && wb_we_i && wb_sel_i == 4'hF) begin
         case (wb_adr_i)
            CTRL_ADDR:    ctrl_r    <= wb_dat_i;
            VTYPE_ADDR:   vtype_r   <= wb_dat_i[15:0];
            PORT_SELECT_ADDR:  port_select_r  <= wb_dat_i[3:0];
            DP_ADDR_ADDR: dp_addr_r <= wb_dat_i[7:0];
            PAE_SEL_ADDR: pae_sel_r <= wb_dat_i[5:0];
            PAE_LO_ADDR:  pae_lo_r  <= wb_dat_i;
            default: ;
         endcase
      end
   end

   // Perfect entries: high word write commits whole entry
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int i = 0; i < N_PAE; i++) begin
            pae_r[i] <= '0;
         end
      end else if (wb_req && wb_we_i && wb_sel_i == 4'hF &&
                   wb_adr_i == PAE_HI_ADDR &&
                   pae_sel_r < 6'(N_PAE)) begin
         pae_r[pae_sel_r] <= {wb_dat_i[17:0], pae_lo_r}; // [R07]
      end
   end

   // Read mux
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wb_dat_o <= '0;
      end else if (wb_req && !wb_we_i && !ram_port_stall) begin
         case (wb_adr_i)
            CTRL_ADDR:    wb_dat_o <= ctrl_r;
            VTYPE_ADDR:   wb_dat_o <= {16'h0000, vtype_r};
            PORT_SELECT_ADDR:  wb_dat_o <= {28'h0000000, port_select_r};
            DP_ADDR_ADDR: wb_dat_o <= {24'h000000, dp_addr_r};
            DP_DATA_ADDR: wb_dat_o <= dp_hit ? ram[dp_addr_r] : '0; // [R18]
            DP_STAT_ADDR: wb_dat_o <= {31'h0, init_busy_r};
            PAE_SEL_ADDR: wb_dat_o <= {26'h0, pae_sel_r};
            PAE_LO_ADDR:  wb_dat_o <= pae_sel_r < 6'(N_PAE) ?
                                      pae_r[pae_sel_r][31:0] : '0;
            PAE_HI_ADDR:  wb_dat_o <= pae_sel_r < 6'(N_PAE) ?
                                      {14'h0, pae_r[pae_sel_r][49:32]} : '0;
            default:      wb_dat_o <= '0;
         endcase
      end
   end

   // Clear sweep after reset; one word per cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         init_busy_r <= 1'b1;
         init_addr_r <= '0;
      end else if (init_busy_r) begin
         init_addr_r <= init_addr_r + 8'h01;
         if (init_addr_r == 8'(RAM_WORDS - 1)) begin
            init_busy_r <= 1'b0; // [R19]
         end
      end
   end

   // Filter RAM: single write port shared by clear and data port
   always_ff @(posedge clock) begin
      if (init_busy_r) begin
         ram[init_addr_r] <= RAM_CLEAR; // [R19]
      end else if (wb_req && wb_we_i && wb_sel_i == 4'hF && dp_hit) begin
         ram[dp_addr_r] <= wb_dat_i; // [R18]
      end
   end

   // Frame parser: collect DA, SA, type, optional tag
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_r <= S_IDLE;
         bcnt_r  <= '0;
         da_r    <= '0;
         sa_r    <= '0;
         type_r  <= '0;
         tci_r   <= '0;
         crc_r   <= CRC_INIT;
         eof_seen_r <= 1'b0;
      end else begin
         // An end inside header or lookup still closes the frame
         eof_seen_r <= state_r != S_IDLE &&
                       (eof_seen_r || (rx_valid && rx_eof));
         case (state_r)
            S_IDLE: begin
               if (rx_valid && rx_sof) begin
                  crc_r   <= crc_byte(CRC_INIT, rx_data); // [R09]
                  da_r    <= {rx_data, 40'h0};
                  bcnt_r  <= 5'd1;
                  state_r <= S_HDR;
               end
            end
            S_HDR: begin
               if (rx_valid) begin
                  bcnt_r <= bcnt_r + 5'd1;
                  if (bcnt_r < 5'd6) begin
                     da_r[47-8*bcnt_r -: 8] <= rx_data;
                     crc_r <= crc_byte(crc_r, rx_data); // [R09]
                  end else if (bcnt_r < 5'd12) begin
                     sa_r[47-8*(bcnt_r-5'd6) -: 8] <= rx_data; // [R02]
                  end else if (bcnt_r == 5'd12) begin
                     type_r[15:8] <= rx_data;
                  end else if (bcnt_r == 5'd13) begin
                     type_r[7:0] <= rx_data;
                  end else if (bcnt_r == 5'd14) begin
                     tci_r[15:8] <= rx_data;
                  end else if (bcnt_r == 5'd15) begin
                     tci_r[7:0] <= rx_data; // [R16]
                  end
                  // First tag only; later tags stay in the payload
                  if (rx_eof || bcnt_r == 5'd17 ||
                      (bcnt_r == 5'd15 && !is_tag)) begin // [R14]
                     state_r <= S_LOOK;
                  end
               end
            end
            S_LOOK: begin
               if (look_r == L_FINISH) begin
                  state_r <= S_BODY;
               end
            end
            S_BODY: begin
               if ((rx_valid && rx_eof) || eof_seen_r) begin
                  state_r <= S_DONE;
               end
            end
            S_DONE: state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Table lookups: hash word then VLAN word, one RAM read each
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         look_r     <= L_HASH;
         ram_q_r    <= '0;
         hash_bit_r <= 1'b0;
      end else if (state_r == S_LOOK) begin
         case (look_r)
            L_HASH: begin
               ram_q_r <= ram[HASH_BASE + {4'h0, crc_r[31:28]}]; // [R11]
               look_r  <= L_VLAN;
            end
            L_VLAN: begin
               hash_bit_r <= ram_q_r[crc_r[27:23]]; // [R11] [R12]
               ram_q_r <= ram[VLAN_BASE + {1'b0, tci_r[11:5]}]; // [R22]
               look_r  <= L_FINISH;
            end
            L_FINISH: begin
               look_r     <= L_HASH;
            end
            default: look_r <= L_HASH;
         endcase
      end
   end

   // Perfect match against every valid entry
   logic [N_PAE-1:0] da_hit;
   logic [N_PAE-1:0] sa_hit;
   generate
      for (genvar g = 0; g < N_PAE; g++) begin : g_pae
         assign da_hit[g] = pae_r[g][PAE_VALID_BIT] &&
                            !pae_r[g][PAE_TYPE_BIT] &&
                            pae_r[g][47:0] == da_r; // [R03] [R04]
         assign sa_hit[g] = pae_r[g][PAE_VALID_BIT] &&
                            pae_r[g][PAE_TYPE_BIT] &&
                            pae_r[g][47:0] == sa_r; // [R03] [R04]
      end
   endgenerate

   // Pass/drop combination
   logic is_bcast;
   logic is_mcast;
   logic hash_use;
   logic dst_ok;
   logic src_ok;
   logic vlan_ok;
   logic drop;
   always_comb begin
      is_bcast = &da_r;
      is_mcast = da_r[40] && !is_bcast;
      hash_use = !is_bcast &&
                 ((is_mcast && ctrl_r[CTL_MHF]) ||
                  (!da_r[40] && ctrl_r[CTL_DHF])); // [R08]
      dst_ok = is_bcast ? !ctrl_r[CTL_BCAST_DISC] : // [R01]
               (is_mcast && ctrl_r[CTL_MCAST_ALL]) ||
               (!da_r[40] && ctrl_r[CTL_UCAST_ALL]) ||
               (ctrl_r[CTL_DPF] && |da_hit) || // [R05]
               (hash_use && hash_bit_r) ||
               (!ctrl_r[CTL_DPF] && !hash_use);
      src_ok  = !ctrl_r[CTL_SPF] || |sa_hit; // [R05] [R06]
      vlan_ok = is_tag ? (!ctrl_r[CTL_VF] || // [R17]
                          ram_q_r[tci_r[4:0]]) : // [R22]
                !ctrl_r[CTL_UNTAG]; // [R15]
      drop = !(dst_ok && src_ok && vlan_ok); // [R06]
   end

   // Stream one cycle behind input; first tag's bytes 14-15 skipped, 12-13 only if type_r, not yet fully reloaded, is a tag type
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         out_data  <= '0;
         out_sof   <= 1'b0;
         out_eof   <= 1'b0;
      end else begin
         out_valid <= 1'b0;
         out_sof   <= 1'b0;
         out_eof   <= 1'b0;
         if (rx_valid && (state_r == S_IDLE ? rx_sof : 1'b1)) begin
            out_valid <= !(state_r == S_HDR && ctrl_r[CTL_STRIP] && is_tag &&
                           bcnt_r >= 5'd12 && bcnt_r < 5'd16) ||
                         bcnt_r < 5'd12; // [R16]
            out_data  <= rx_data;
            out_sof   <= state_r == S_IDLE;
            out_eof   <= rx_eof;
         end
      end
   end

   // Status emitted once the verdict is settled
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         stat_valid    <= 1'b0;
         stat_drop     <= 1'b0;
         stat_tagged   <= 1'b0;
         stat_vlan_tag <= '0;
         stat_hash_hit <= 1'b0;
      end else begin
         stat_valid <= 1'b0;
         if (state_r == S_LOOK && look_r == L_FINISH) begin
            stat_valid    <= 1'b1; // [R23]
            stat_drop     <= drop; // [R23]
            stat_tagged   <= is_tag; // [R16]
            stat_vlan_tag <= is_tag ? tci_r : 16'h0000; // [R16]
            stat_hash_hit <= hash_use && hash_bit_r; // [R20]
         end
      end
   end
endmodule

// [tb/rx_frame_source.sv]
`timescale 1ns/1ps
// Receive-path source: one byte a cycle, no gaps inside a frame
module rx_frame_source (
   input  logic       clock,
   output logic       rx_valid,
   output logic       rx_sof,
   output logic       rx_eof,
   output logic [7:0] rx_data
);
   initial begin
      rx_valid = 1'b0;
      rx_sof   = 1'b0;
      rx_eof   = 1'b0;
      rx_data  = 8'h00;
   end

   // Idle data shows the inverse of the last byte, so stale data never
   // passes for a held value; the trailing edge gives the idle gap
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i]) begin
         rx_valid <= 1'b1;
         rx_sof   <= (i == 0);
         rx_eof   <= (i == q.size() - 1);
         rx_data  <= q[i];
         @(posedge clock);
      end
      rx_valid <= 1'b0;
      rx_sof   <= 1'b0;
      rx_eof   <= 1'b0;
      rx_data  <= ~q[q.size() - 1];
      @(posedge clock);
   endtask
endmodule

// [tb/rx_filter_engine_asserts.sv]
`timescale 1ns/1ps
module rx_filter_engine_asserts (
   input logic       clock,
   input logic       reset_n,
   input logic       wb_cyc_i,
   input logic       wb_stb_i,
   input logic       wb_ack_o,
   input logic       rx_valid,
   input logic       rx_sof,
   input logic       rx_eof,
   input logic [7:0] rx_data,
   input logic       out_valid,
   input logic       out_sof,
   input logic       out_eof,
   input logic [7:0] out_data,
   input logic       stat_valid,
   input logic       stat_drop,
   input logic       stat_tagged,
   input logic       stat_hash_hit
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   // Bus answers: single pulses, only after a request
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_no_ack_idle: assert property (
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack while bus idle");

   // Status: one pulse per frame, within a bounded time of its start
   a_stat_one_pulse: assert property (stat_valid |=> !stat_valid)
      else $error("status pulse too long");
   a_stat_bounded: assert property (
      rx_valid && rx_sof |-> ##[16:40] stat_valid)
      else $error("no status for frame");
   a_stat_fields_hold: assert property (
      !stat_valid |-> $stable(stat_drop) && $stable(stat_hash_hit))
      else $error("status changed without pulse");

   // Output stream trails input by one cycle; only bytes 12 to 15 of a frame may vanish
   a_out_from_in: assert property (out_valid |-> $past(rx_valid))
      else $error("output byte without input");
   a_sof_passes: assert property (
      $past(rx_valid && rx_sof) |->
      out_valid && out_sof && out_data == $past(rx_data))
      else $error("first byte not forwarded");
   a_eof_passes: assert property (
      $past(rx_valid && rx_eof) |-> out_valid && out_eof)
      else $error("last byte not forwarded");

   c_dropped: cover property (stat_valid && stat_drop);
   c_hash_accept: cover property (stat_valid && stat_hash_hit);
   c_tagged: cover property (stat_valid && stat_tagged);
endmodule

bind rx_filter_engine rx_filter_engine_asserts u_asserts (
   .clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rx_valid(rx_valid),
   .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data),
   .out_valid(out_valid), .out_sof(out_sof), .out_eof(out_eof),
   .out_data(out_data), .stat_valid(stat_valid), .stat_drop(stat_drop),
   .stat_tagged(stat_tagged), .stat_hash_hit(stat_hash_hit));

// [tb/test_rx_filter_engine.sv]
`timescale 1ns/1ps
module test_rx_filter_engine;
   import rx_filter_pkg::*;
   localparam logic [47:0] UA = 48'h0200_0000_0001;
   localparam logic [47:0] UB = 48'h0200_0000_0002;
   localparam logic [47:0] UC = 48'h0200_0000_0003;
   localparam logic [47:0] MC = 48'h0100_5E00_0001;
   localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
   localparam logic [47:0] SA = 48'h0200_0000_00AA;
   localparam logic [47:0] SB = 48'h0200_0000_00BB;
   localparam logic [31:0] T1 = 32'h8100_0123;
   localparam logic [31:0] T2 = 32'h8100_0456;
   localparam logic [31:0] TQ = 32'h88A8_0123;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, r, ca, cm;
   logic        wb_ack_o, rx_valid, rx_sof, rx_eof, out_valid;
   logic [7:0]  rx_data, out_data;
   logic        out_sof, out_eof, stat_valid, stat_drop, stat_tagged;
   logic        stat_hash_hit, st_drop, st_tag, st_hash;
   logic [15:0] stat_vlan_tag, st_vid;
   int          err_total = 0, cmp_count = 0, tick = 0, nst = 0, nout = 0;

   rx_filter_engine DUT (
      .clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rx_valid(rx_valid), .rx_sof(rx_sof),
      .rx_eof(rx_eof), .rx_data(rx_data), .out_valid(out_valid),
      .out_data(out_data), .out_sof(out_sof), .out_eof(out_eof),
      .stat_valid(stat_valid), .stat_drop(stat_drop),
      .stat_tagged(stat_tagged), .stat_vlan_tag(stat_vlan_tag),
      .stat_hash_hit(stat_hash_hit));
   rx_frame_source src (.clock(clock), .rx_valid(rx_valid),
      .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data));

   initial begin
      forever #5 clock = ~clock;
   end

   // Status is caught here: long frames see it before their last byte
   always @(posedge clock) begin
      tick++;
      if (out_valid === 1'b1) nout++;
      if (stat_valid === 1'b1) begin
         st_drop = stat_drop;
         st_tag = stat_tagged;
         st_hash = stat_hash_hit;
         st_vid = stat_vlan_tag;
         nst++;
      end
      if (tick == 20000) begin
         err_total++;
         final_report;
      end
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One classic cycle; no latency assumed, idle edge after release
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clock);
      while (wb_ack_o !== 1'b1) @(posedge clock);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask

   task automatic dp(input logic [7:0] a, input logic [31:0] d);
      wr(DP_ADDR_ADDR, {24'h0, a});
      wr(DP_DATA_ADDR, d);
   endtask

   task automatic pae(input int n, input logic [1:0] vt,
                      input logic [47:0] a);
      wr(PAE_SEL_ADDR, n);
      wr(PAE_LO_ADDR, a[31:0]);
      wr(PAE_HI_ADDR, {14'h0, vt, a[47:32]});
   endtask

   // Serial form of the byte-wise hash update, data bit 0 first
   function automatic logic [31:0] crc(input logic [47:0] a);
      logic [31:0] c;
      c = CRC_INIT;
      for (int b = 5; b >= 0; b--)
         for (int k = 0; k < 8; k++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ a[8*b+k]) ? 32'h04C1_1DB7 : 0);
      return c;
   endfunction

   // Frame: DA, SA, up to two tags, type, payload; waits for status
   task automatic run(input logic [31:0] c, input logic [47:0] da, sa,
                      input logic [31:0] t1, t2, input logic xd,
                      input int np = 6);
      logic [7:0] q[$];
      int n0;
      wr(CTRL_ADDR, c);
      for (int i = 47; i >= 0; i -= 8) q.push_back(da[i-:8]);
      for (int i = 47; i >= 0; i -= 8) q.push_back(sa[i-:8]);
      if (t1 != 0) for (int i = 31; i >= 0; i -= 8) q.push_back(t1[i-:8]);
      if (t2 != 0) for (int i = 31; i >= 0; i -= 8) q.push_back(t2[i-:8]);
      q.push_back(8'h08);
      q.push_back(8'h00);
      for (int i = 0; i < np; i++) q.push_back(8'h30 + i[7:0]);
      n0 = nst;
      nout = 0;
      src.send(q);
      while (nst == n0) @(posedge clock);
      repeat (4) @(posedge clock);
      chk("drop", xd, st_drop);
      $display("frame test %0d done", nst);
   endtask

   initial begin
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      rd(CTRL_ADDR, r);
      chk("control reset", 32'h0000_0060, r);
      rd(VTYPE_ADDR, r);
      chk("value_a reset", 32'h0000_8100, r);
      // Partial byte enables: acked but the register keeps its value
      wb_sel_i <= 4'h1;
      wr(CTRL_ADDR, 32'h0000_0000);
      wb_sel_i <= 4'hF;
      rd(CTRL_ADDR, r);
      chk("partial write", 32'h0000_0060, r);
      rd(8'hFC, r);
      chk("unmapped read", 32'h0, r);
      wr(PORT_SELECT_ADDR, {28'h0, PORT_FILTER});
      rd(DP_STAT_ADDR, r);
      chk("clear busy", 32'h1, r);
      rd(DP_DATA_ADDR, r);
      chk("ram cleared", 32'h0, r);
      chk("wait states", 32'h1, {31'h0, tick >= 262});
      $display("register test done");
      ca = crc(UA);
      cm = crc(MC);
      // Hash filtering
      run(32'h60, UA, SA, 0, 0, 1'b1);
      dp(HASH_BASE + {4'h0, ca[31:28]}, 32'h1 << ca[27:23]);
      rd(DP_DATA_ADDR, r);
      chk("hash word", 32'h1 << ca[27:23], r);
      run(32'h60, UA, SA, 0, 0, 1'b0);
      chk("hash hit", 32'h1, st_hash);
      run(32'h60, BC, SA, 0, 0, 1'b0);
      chk("hash hit", 32'h0, st_hash);
      run(32'h64, BC, SA, 0, 0, 1'b1);
      // Shortest frames: end inside the header, then inside the lookup
      run(32'h60, BC, SA, 0, 0, 1'b0, 2);
      chk("short frame bytes", 32'd16, nout);
      run(32'h60, BC, SA, 0, 0, 1'b0, 4);
      run(32'h20, MC, SA, 0, 0, cm[31:23] != ca[31:23]);
      run(32'h22, MC, SA, 0, 0, 1'b0);
      run(32'h41, UB, SA, 0, 0, 1'b0);
      run(32'h20, UB, SA, 0, 0, 1'b0);
      // Perfect filtering, last entry as the boundary
      pae(32, 2'b10, UB);
      run(32'h08, UB, SA, 0, 0, 1'b0);
      pae(32, 2'b00, UB);
      run(32'h08, UB, SA, 0, 0, 1'b1);
      pae(0, 2'b11, SA);
      pae(32, 2'b10, UB);
      run(32'h08, SA, SB, 0, 0, 1'b1);
      run(32'h10, UC, SA, 0, 0, 1'b0);
      run(32'h18, UB, SA, 0, 0, 1'b0);
      run(32'h18, UB, SB, 0, 0, 1'b1);
      run(32'h18, UC, SA, 0, 0, 1'b1);
      run(32'h58, UA, SA, 0, 0, 1'b0);
      // VLAN filtering; VID 123h is word 9, bit 3
      run(32'h100, UB, SA, T1, 0, 1'b1);
      dp(VLAN_BASE + 8'h09, 32'h0000_0008);
      run(32'h100, UB, SA, T1, 0, 1'b0);
      chk("tagged", 32'h1, st_tag);
      chk("vid", 32'h123, {20'h0, st_vid[11:0]});
      chk("kept bytes", 32'd24, nout);
      run(32'h300, UB, SA, T1, T2, 1'b0);
      chk("vid", 32'h123, {20'h0, st_vid[11:0]});
      chk("stripped bytes", 32'd24, nout);
      run(32'h180, UB, SA, 0, 0, 1'b1);
      run(32'h100, UB, SA, 0, 0, 1'b0);
      chk("tagged", 32'h0, st_tag);
      run(32'h180, UB, SA, TQ, 0, 1'b1);
      wr(VTYPE_ADDR, 32'h0000_88A8);
      run(32'h180, UB, SA, TQ, 0, 1'b0);
      run(32'h180, UB, SA, T1, 0, 1'b0);
      final_report;
   end
endmodule
